// ===== rspt_pkg.sv
// Constants, register map and encodings for the reset status and power-up timer block.
// Assumes a 250 MHz system clock and a classic Wishbone slave with 32-bit data.
`default_nettype none

package rspt_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RC_PERIOD_NS = 32;
  localparam int RC_PERIOD_PS = RC_PERIOD_NS * 1000 * 1000 / 1000;
  localparam int RC_TICK_CYCLES = (RC_PERIOD_PS * 1000) / CLK_PERIOD_PS;
  localparam int TICK_CNT_W = 16;
  localparam int POWERUP_TIMER_BITS = 11;
  localparam int PIN_FILTER_NS = 20;
  localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PIN_FILT_W = 4;

  // ==========================================================================
  // Program counter
  localparam int PC_W = 21;
  localparam logic [20:0] PC_RESET_VEC = 21'h000000;
  localparam logic [20:0] PC_HIGH_VEC = 21'h000008;
  localparam logic [20:0] PC_LOW_VEC = 21'h000018;
  localparam logic [20:0] PC_STEP = 21'h000002;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_STACK = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_TIMER = 8'h0C;

  // Status register fields
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_POWERON = 1;
  localparam int BIT_POWERDOWN = 2;
  localparam int BIT_TIMEOUT = 3;
  localparam int BIT_RESET_INSTR = 4;
  // Stack register fields
  localparam int BIT_STACK_FULL = 0;
  localparam int BIT_STACK_UNDERFLOW = 1;
  // Control register fields
  localparam int BIT_STACK_RST_EN = 0;
  localparam int BIT_PRIO_EN = 7;
  // Timer register fields
  localparam int BIT_POWERUP_TIMER_EXPIRED = 16;
  localparam int BIT_CORE_RESET = 17;

  localparam logic CTRL_STACK_RST_EN_RST = 1'b1;
  localparam logic CTRL_PRIO_EN_RST = 1'b0;

  // ==========================================================================
  // Power modes
  typedef enum logic [1:0] {
    RSPT_MODE_FULL = 2'b00,
    RSPT_MODE_RUN = 2'b01,
    RSPT_MODE_IDLE = 2'b10,
    RSPT_MODE_SLEEP = 2'b11
  } rspt_mode_t;

endpackage

`default_nettype wire

// ===== rspt_top.sv
// Reset sequencing, reset-cause flags and always-on power-up timer.
// Assumes all inputs synchronous to clk_i and a classic Wishbone master.
`default_nettype none

module rspt_top #(
  parameter int RC_TICK_CYCLES = rspt_pkg::RC_TICK_CYCLES,
  parameter int POWERUP_TIMER_BITS = rspt_pkg::POWERUP_TIMER_BITS,
  parameter bit BROWNOUT_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Supply detectors and reset pin
  input wire logic por_pulse_i,
  input wire logic brownout_i,
  input wire logic external_reset_pin_n_i,
  // Core events
  input wire logic [1:0] power_mode_i,
  input wire logic wdt_timeout_i,
  input wire logic reset_instr_i,
  input wire logic stack_full_i,
  input wire logic stack_underflow_i,
  input wire logic interrupt_wake_i,
  input wire logic sleep_instr_i,
  input wire logic clrwdt_instr_i,
  input wire logic high_priority_global_enable_i,
  input wire logic low_priority_global_enable_i,
  input wire logic [20:0] cpu_pc_i,
  // Core control
  output logic core_reset_o,
  output logic pc_load_o,
  output logic [20:0] pc_value_o,
  output logic wake_o,
  output logic [4:0] status_flags_o
);

  // ==========================================================================
  // RC tick divider
  logic [rspt_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
  logic rc_tick_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= '0;
      rc_tick_reg <= 1'b0;
    end else if (tick_cnt_reg == rspt_pkg::TICK_CNT_W'(RC_TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      rc_tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      rc_tick_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Supply detectors sampled on the RC tick
  logic por_s_reg;
  logic bor_s_reg;
  logic por_event_reg;
  logic bor_event_reg;
  // Levels are resampled once per RC tick so that each flag update
  // comes from a single clean edge of the slow clock domain

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_s_reg <= 1'b1;
      bor_s_reg <= 1'b0;
      por_event_reg <= 1'b0;
      bor_event_reg <= 1'b0;
    end else if (rc_tick_reg) begin
      por_s_reg <= por_pulse_i;
      bor_s_reg <= brownout_i && BROWNOUT_PRESENT;
      por_event_reg <= por_pulse_i && !por_s_reg;
      bor_event_reg <= brownout_i && BROWNOUT_PRESENT && !bor_s_reg;
    end else begin
      por_event_reg <= 1'b0;
      bor_event_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Power-up timer, always enabled
  logic [POWERUP_TIMER_BITS-1:0] powerup_timer_cnt_reg;
  logic powerup_timer_expired_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      powerup_timer_cnt_reg <= '0;
      powerup_timer_expired_reg <= 1'b0;
    end else if (por_s_reg || bor_s_reg) begin
      powerup_timer_cnt_reg <= '0;
      powerup_timer_expired_reg <= 1'b0;
    end else if (rc_tick_reg && !powerup_timer_expired_reg) begin
      powerup_timer_cnt_reg <= powerup_timer_cnt_reg + 1'b1;
      if (&powerup_timer_cnt_reg) begin
        powerup_timer_expired_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Reset pin glitch filter; the pin is input only
  logic [rspt_pkg::PIN_FILT_W-1:0] pin_cnt_reg;
  logic pin_low_reg;
  logic pin_fall_reg;
  // A low level must last the filter count before it counts;
  // shorter pulses restart the count and never reach the core

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_cnt_reg <= '0;
      pin_low_reg <= 1'b0;
      pin_fall_reg <= 1'b0;
    end else begin
      pin_fall_reg <= 1'b0;
      if (external_reset_pin_n_i) begin
        pin_cnt_reg <= '0;
        pin_low_reg <= 1'b0;
      end else if (pin_cnt_reg
                   == rspt_pkg::PIN_FILT_W'(rspt_pkg::PIN_FILTER_CYCLES - 1)) begin
        pin_fall_reg <= !pin_low_reg;
        pin_low_reg <= 1'b1;
      end else begin
        pin_cnt_reg <= pin_cnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Control register
  logic stack_rst_en_reg;
  logic prio_en_reg;
  logic wb_write;
  logic [1:0] mode;
  logic asleep;

  assign wb_write = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign mode = power_mode_i;
  assign asleep = (mode == rspt_pkg::RSPT_MODE_IDLE) || (mode == rspt_pkg::RSPT_MODE_SLEEP);

  // Bus decode shared by the register write paths and the read mux
  logic wb_req;
  logic wr_status;
  logic wr_stack;
  logic wr_control;

  // Write strobe for one register: lands on the edge that sees ack high
  function automatic logic wr_hit(input logic wr, input logic [7:0] adr,
                                  input logic [7:0] target);
    wr_hit = wr && (adr == target);
  endfunction

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_status = wr_hit(wb_write, wb_adr_i, rspt_pkg::ADDR_STATUS);
  assign wr_stack = wr_hit(wb_write, wb_adr_i, rspt_pkg::ADDR_STACK);
  assign wr_control = wr_hit(wb_write, wb_adr_i, rspt_pkg::ADDR_CONTROL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_rst_en_reg <= rspt_pkg::CTRL_STACK_RST_EN_RST;
      prio_en_reg <= rspt_pkg::CTRL_PRIO_EN_RST;
    end else if (wr_control) begin
      stack_rst_en_reg <= wb_dat_i[rspt_pkg::BIT_STACK_RST_EN];
      prio_en_reg <= wb_dat_i[rspt_pkg::BIT_PRIO_EN];
    end
  end

  // ==========================================================================
  // Reset-cause and stack flags; hardware events win over software writes
  logic ri_reg;
  logic to_reg;
  logic pd_reg;
  logic po_reg;
  logic bo_reg;
  logic sf_reg;
  logic su_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ri_reg <= 1'b1;
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
      po_reg <= 1'b0;
      bo_reg <= 1'b0;
      sf_reg <= 1'b0;
      su_reg <= 1'b0;
    end else begin
      if (wr_status) begin
        ri_reg <= wb_dat_i[rspt_pkg::BIT_RESET_INSTR];
        po_reg <= wb_dat_i[rspt_pkg::BIT_POWERON];
        bo_reg <= wb_dat_i[rspt_pkg::BIT_BROWNOUT];
      end
      if (wr_stack) begin
        sf_reg <= wb_dat_i[rspt_pkg::BIT_STACK_FULL];
        su_reg <= wb_dat_i[rspt_pkg::BIT_STACK_UNDERFLOW];
      end
      if (por_event_reg) begin
        ri_reg <= 1'b1;
        to_reg <= 1'b1;
        pd_reg <= 1'b1;
        po_reg <= 1'b0;
        bo_reg <= 1'b0;
        sf_reg <= 1'b0;
        su_reg <= 1'b0;
      end else if (bor_event_reg) begin
        // Power-on and stack flags keep their values on a brown-out
        po_reg <= po_reg;
        ri_reg <= 1'b1;
        to_reg <= 1'b1;
        pd_reg <= 1'b1;
        bo_reg <= 1'b0;
      end else if (pin_fall_reg) begin
        if (mode == rspt_pkg::RSPT_MODE_RUN) begin
          to_reg <= 1'b1;
        end else if (asleep) begin
          to_reg <= 1'b1;
          pd_reg <= 1'b0;
        end
      end else if (wdt_timeout_i) begin
        to_reg <= 1'b0;
        if (asleep) begin
          pd_reg <= 1'b0;
        end
      end else if (reset_instr_i) begin
        ri_reg <= 1'b0;
      end else if (interrupt_wake_i && asleep) begin
        pd_reg <= 1'b0;
      end else if (sleep_instr_i) begin
        to_reg <= 1'b1;
        pd_reg <= 1'b0;
      end else if (clrwdt_instr_i) begin
        to_reg <= 1'b1;
        pd_reg <= 1'b1;
      end
      if (stack_full_i && stack_rst_en_reg) begin
        sf_reg <= 1'b1;
      end
      if (stack_underflow_i) begin
        su_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Program counter load, wake and core reset
  logic evt_reset;
  logic stack_reset;

  assign stack_reset = stack_rst_en_reg && (stack_full_i || stack_underflow_i);
  assign evt_reset = reset_instr_i || stack_reset || (wdt_timeout_i && !asleep);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_load_o <= 1'b1;
      pc_value_o <= rspt_pkg::PC_RESET_VEC;
      wake_o <= 1'b0;
    end else begin
      pc_load_o <= 1'b0;
      wake_o <= 1'b0;
      if (por_event_reg || bor_event_reg || pin_fall_reg || evt_reset) begin
        pc_load_o <= 1'b1;
        pc_value_o <= rspt_pkg::PC_RESET_VEC;
      end else if (wdt_timeout_i && asleep) begin
        pc_load_o <= 1'b1;
        wake_o <= 1'b1;
        pc_value_o <= cpu_pc_i + rspt_pkg::PC_STEP;
      end else if (interrupt_wake_i && asleep) begin
        pc_load_o <= 1'b1;
        wake_o <= 1'b1;
        if (high_priority_global_enable_i) begin
          pc_value_o <= rspt_pkg::PC_HIGH_VEC;
        end else if (low_priority_global_enable_i) begin
          pc_value_o <= rspt_pkg::PC_LOW_VEC;
        end else begin
          pc_value_o <= cpu_pc_i + rspt_pkg::PC_STEP;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
    end else begin
      // Supply low or timer still running holds the core
      // Filtered pin low holds it; once the timer has expired the pin
      // alone decides, so a late release starts execution at once
      // Pulse resets from the core give a single cycle of reset
      core_reset_o <= por_s_reg || bor_s_reg
                      || !powerup_timer_expired_reg
                      || pin_low_reg
                      || evt_reset;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_flags_o <= '0;
    end else begin
      status_flags_o <= {ri_reg, to_reg, pd_reg, po_reg, bo_reg};
    end
  end

  // ==========================================================================
  // Wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          rspt_pkg::ADDR_STATUS: begin
            wb_dat_o[rspt_pkg::BIT_RESET_INSTR] <= ri_reg;
            wb_dat_o[rspt_pkg::BIT_TIMEOUT] <= to_reg;
            wb_dat_o[rspt_pkg::BIT_POWERDOWN] <= pd_reg;
            wb_dat_o[rspt_pkg::BIT_POWERON] <= po_reg;
            wb_dat_o[rspt_pkg::BIT_BROWNOUT] <= bo_reg;
          end
          rspt_pkg::ADDR_STACK: begin
            wb_dat_o[rspt_pkg::BIT_STACK_FULL] <= sf_reg;
            wb_dat_o[rspt_pkg::BIT_STACK_UNDERFLOW] <= su_reg;
          end
          rspt_pkg::ADDR_CONTROL: begin
            wb_dat_o[rspt_pkg::BIT_STACK_RST_EN] <= stack_rst_en_reg;
            wb_dat_o[rspt_pkg::BIT_PRIO_EN] <= prio_en_reg;
          end
          rspt_pkg::ADDR_TIMER: begin
            wb_dat_o[POWERUP_TIMER_BITS-1:0] <= powerup_timer_cnt_reg;
            wb_dat_o[rspt_pkg::BIT_POWERUP_TIMER_EXPIRED] <= powerup_timer_expired_reg;
            wb_dat_o[rspt_pkg::BIT_CORE_RESET] <= core_reset_o;
          end
          default: begin
            wb_dat_o <= '0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== rspt_top_properties.sv
// Port assertions for the reset sequencer.
// Assumes it is bound into rspt_top.
`default_nettype none
module rspt_top_properties #(
  parameter int RC_TICK_CYCLES = 4
) (
  // Clock, reset, bus
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  // Supply and pin
  input wire logic por_pulse_i, brownout_i, external_reset_pin_n_i,
  // Core events
  input wire logic [1:0] power_mode_i,
  input wire logic wdt_timeout_i, reset_instr_i, interrupt_wake_i,
  input wire logic high_priority_global_enable_i, low_priority_global_enable_i,
  input wire logic [20:0] cpu_pc_i,
  // Core control
  input wire logic core_reset_o, pc_load_o, wake_o,
  input wire logic [20:0] pc_value_o,
  input wire logic [4:0] status_flags_o
);
  localparam int SUP_LAT = RC_TICK_CYCLES + 3;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====================
  // Properties
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  por_hold_a: assert property (por_pulse_i |-> ##[0:SUP_LAT] core_reset_o)
    else $error("no reset during power-on");
  release_a: assert property ($fell(core_reset_o) |->
    external_reset_pin_n_i && !por_pulse_i && !brownout_i) else $error("early release");
  pin_hold_a: assert property (!external_reset_pin_n_i [*8] |-> ##[0:4] core_reset_o)
    else $error("pin low without reset");
  bor_flags_a: assert property (brownout_i [*8] |-> status_flags_o[0] == 1'b0
    && status_flags_o[4:2] == 3'b111) else $error("brown-out flags wrong");
  wdt_wake_a: assert property (wdt_timeout_i && power_mode_i[1] && !core_reset_o
    |=> pc_load_o && wake_o && !core_reset_o && pc_value_o == $past(cpu_pc_i) + 21'h000002)
    else $error("watchdog wake wrong");
  wdt_reset_a: assert property (wdt_timeout_i && !power_mode_i[1] && !core_reset_o
    |=> pc_load_o && !wake_o && pc_value_o == 21'h000000) else $error("watchdog reset wrong");
  wdt_flag_a: assert property (wdt_timeout_i && !core_reset_o |-> ##2 !status_flags_o[3])
    else $error("timeout flag not cleared");
  int_vec_a: assert property (interrupt_wake_i && power_mode_i[1] && !wdt_timeout_i
    && !reset_instr_i && !core_reset_o |=> pc_load_o && wake_o && pc_value_o ==
    ($past(high_priority_global_enable_i) ? 21'h000008 : $past(low_priority_global_enable_i)
    ? 21'h000018 : $past(cpu_pc_i) + 21'h000002) ##1 !status_flags_o[2])
    else $error("interrupt wake wrong");
  rinstr_a: assert property (reset_instr_i && !wdt_timeout_i && !core_reset_o
    |=> pc_load_o && pc_value_o == 21'h000000 ##1 !status_flags_o[4])
    else $error("reset instruction wrong");
endmodule
bind rspt_top rspt_top_properties #(.RC_TICK_CYCLES(RC_TICK_CYCLES)) u_props (.*);
`default_nettype wire

// ===== rspt_pin_model.sv
// External reset pin driver: pulls the pin low for a requested span.
// Assumes a pull-up on the pin, so it idles high.
`default_nettype none
module rspt_pin_model (
  // Clock and request
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] low_cycles_i,
  // Pin
  output logic pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg = 8'h00;
  always @(posedge clk_i) begin
    if (go_i) cnt_reg <= low_cycles_i;
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
  end
  assign pin_n_o = (cnt_reg == 8'h00);
endmodule
`default_nettype wire

// ===== rspt_top_tb.sv
// Self-checking bench for the reset sequencer with a flag model.
// Assumes a tick of 4 clocks and a 3-bit power-up timer.
`default_nettype none
module rspt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  localparam int POWERUP_TIMER = 8 * TICK;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
  logic por = 1'b1, bor = 1'b0, wdt = 1'b0, rins = 1'b0, sful = 1'b0, sunf = 1'b0;
  logic intw = 1'b0, hen = 1'b0, len = 1'b0, ack, pin_n, cres, pcl, wake;
  logic [7:0] adr = 8'h00, plen = 8'h00;
  logic [1:0] mode = 2'b00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [20:0] cpc = 21'h0, pcv, lpc, exp_pc;
  logic [4:0] flags, mf;
  int err_count = 0, checks = 0, seed = 32'hA1E0, loads = 0, n;
  rspt_top #(.RC_TICK_CYCLES(TICK), .POWERUP_TIMER_BITS(3)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .por_pulse_i(por), .brownout_i(bor),
    .external_reset_pin_n_i(pin_n), .power_mode_i(mode), .wdt_timeout_i(wdt),
    .reset_instr_i(rins), .stack_full_i(sful), .stack_underflow_i(sunf),
    .interrupt_wake_i(intw), .sleep_instr_i(1'b0), .clrwdt_instr_i(1'b0),
    .high_priority_global_enable_i(hen), .low_priority_global_enable_i(len),
    .cpu_pc_i(cpc), .core_reset_o(cres), .pc_load_o(pcl), .pc_value_o(pcv),
    .wake_o(wake), .status_flags_o(flags));
  rspt_pin_model pin (.clk_i(clk_i), .go_i(go), .low_cycles_i(plen), .pin_n_o(pin_n));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (pcl === 1'b1) begin
      loads <= loads + 1;
      lpc <= pcv;
    end
  end
  // ====================
  // Checking and bus tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (i >= 20) begin
      err_count++;
      conclude();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    cmp(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic wrel(output int c);
    c = 0;
    while (cres !== 1'b0 && c < 200) begin
      @(negedge clk_i);
      c++;
    end
    if (c >= 200) begin
      err_count++;
      conclude();
    end
  endtask
  // Event k: 0 wdt, 1 irq, 2 reset instr, 3 full, 4 underflow, 5/6 irq with enable
  task automatic ev(input int k, input logic [1:0] m, input int v, input logic wk);
    logic [20:0] p;
    p = 21'($random(seed));
    @(posedge clk_i);
    cpc <= p;
    mode <= m;
    case (k)
      0: wdt <= 1'b1;
      1: intw <= 1'b1;
      2: rins <= 1'b1;
      3: sful <= 1'b1;
      4: sunf <= 1'b1;
      5: {intw, hen} <= 2'b11;
      default: {intw, len} <= 2'b11;
    endcase
    @(posedge clk_i);
    {wdt, intw, rins, sful, sunf, hen, len} <= 7'h00;
    @(negedge clk_i);
    exp_pc = v == 1 ? p + 21'h2 : v == 2 ? 21'h8 : v == 3 ? 21'h18 : 21'h0;
    cmp(wake, wk);
    cmp(pcl, v < 4);
    if (v < 4) cmp(pcv, exp_pc);
    @(negedge clk_i);
    cmp(flags, mf);
  endtask
  task automatic pinr(input logic [1:0] m, input logic [7:0] l);
    int l0;
    int c;
    @(posedge clk_i);
    mode <= m;
    plen <= l;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    l0 = loads;
    repeat (14) @(negedge clk_i);
    cmp(cres, l > 8'd4);
    cmp(loads != l0, l > 8'd4);
    if (l > 8'd4) cmp(lpc, 32'h0);
    wrel(c);
    cmp(c <= TICK + 5, 1'b1);
    @(negedge clk_i);
    cmp(flags, mf);
  endtask
  // ====================
  // Main sequence
  initial begin
    mf = 5'b11100;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    por <= 1'b0;
    wrel(n);
    cmp(n >= POWERUP_TIMER - TICK && n <= POWERUP_TIMER + 3 * TICK, 1'b1);
    cmp(flags, mf);
    rd(8'h04, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h00, 32'h12);
    mf = 5'b11110;
    rd(8'h00, {27'h0, mf});
    mf[3] = 1'b0;
    ev(0, 2'd0, 0, 1'b0);
    ev(0, 2'd1, 0, 1'b0);
    mf[2] = 1'b0;
    ev(0, 2'd2, 1, 1'b1);
    ev(0, 2'd3, 1, 1'b1);
    ev(1, 2'd0, 4, 1'b0);
    ev(1, 2'd3, 1, 1'b1);
    ev(5, 2'd2, 2, 1'b1);
    ev(6, 2'd3, 3, 1'b1);
    mf[4] = 1'b0;
    ev(2, 2'd0, 0, 1'b0);
    ev(3, 2'd0, 0, 1'b0);
    rd(8'h04, 32'h1);
    wr(8'h08, 32'h0);
    ev(4, 2'd0, 4, 1'b0);
    rd(8'h04, 32'h3);
    wr(8'h00, 32'h12);
    mf[4] = 1'b1;
    rd(8'h00, {27'h0, mf});
    pinr(2'd0, 8'd16);
    mf[3] = 1'b1;
    pinr(2'd1, 8'd16);
    pinr(2'd0, 8'd2);
    @(posedge clk_i);
    bor <= 1'b1;
    repeat (10) @(posedge clk_i);
    bor <= 1'b0;
    repeat (12) @(negedge clk_i);
    cmp(cres, 1'b1);
    @(posedge clk_i);
    bor <= 1'b1;
    repeat (10) @(posedge clk_i);
    bor <= 1'b0;
    wrel(n);
    cmp(n >= POWERUP_TIMER - TICK, 1'b1);
    mf = {3'b111, mf[1], 1'b0};
    cmp(flags, mf);
    rd(8'h00, {27'h0, mf});
    rd(8'h04, 32'h3);
    mf[3] = 1'b0;
    ev(0, 2'd0, 0, 1'b0);
    mf[3] = 1'b1;
    mf[2] = 1'b0;
    pinr(2'd2, 8'd16);
    conclude();
  end
endmodule
`default_nettype wire
